// [rtl/elc_map.vh]
// Register offsets, field widths and reset values of the edge line controller.
`ifndef ELC_MAP_VH
`define ELC_MAP_VH

`define ELC_LINES 19
`define ELC_LINE_MSB 18
`define ELC_ADDR_W 8
`define ELC_DATA_W 32
`define ELC_PAD_W 13

`define ELC_OFF_IRQ_EN 8'h00
`define ELC_OFF_EVENT_EN 8'h04
`define ELC_OFF_RISE_SEL 8'h08
`define ELC_OFF_FALL_SEL 8'h0c
`define ELC_OFF_SOFT_TRIG 8'h10
`define ELC_OFF_PENDING 8'h14
`define ELC_OFF_LINE_LEVEL 8'h18

`define ELC_RESET_VAL 19'h00000
`define ELC_PEND_RESET 19'h00000
`define ELC_SYNC_ARM_W 3

`endif

// [rtl/elc_line_sync.v]
// Two-stage line synchroniser with single-cycle rising and falling detection.
`timescale 1ns/10ps
`default_nettype none
`include "elc_map.vh"

module elc_line_sync (
	input wire clock,
	input wire rst,
	input wire [`ELC_LINE_MSB:0] line_in,
	output wire [`ELC_LINE_MSB:0] level,
	output wire [`ELC_LINE_MSB:0] rise,
	output wire [`ELC_LINE_MSB:0] fall
);

	// Edges are held off until the history stage holds a real sample, so a
	// line that is already high when reset ends gives no false rising edge.
	reg [`ELC_SYNC_ARM_W-1:0] arm;

	always @(posedge clock) begin
		if (rst) begin
			arm <= {`ELC_SYNC_ARM_W{1'b0}};
		end else begin
			arm <= {arm[`ELC_SYNC_ARM_W-2:0], 1'b1};
		end
	end

	genvar i;
	generate
		for (i = 0; i < `ELC_LINES; i = i + 1) begin : g_line
			reg meta;
			reg stab;
			reg prev;
			always @(posedge clock) begin
				if (rst) begin
					meta <= 1'b0;
					stab <= 1'b0;
					prev <= 1'b0;
				end else begin
					meta <= line_in[i]; // RL16
					stab <= meta; // RL16
					prev <= stab;
				end
			end
			assign level[i] = stab;
			assign rise[i] = arm[`ELC_SYNC_ARM_W-1] & stab & ~prev; // RL16
			assign fall[i] = arm[`ELC_SYNC_ARM_W-1] & ~stab & prev; // RL16
		end
	endgenerate

endmodule
`default_nettype wire

// [rtl/elc_trig.v]
// Per-line trigger selection and routing to pending and event paths.
`timescale 1ns/10ps
`default_nettype none
`include "elc_map.vh"

module elc_trig (
	input wire [`ELC_LINE_MSB:0] rise,
	input wire [`ELC_LINE_MSB:0] fall,
	input wire [`ELC_LINE_MSB:0] rise_sel,
	input wire [`ELC_LINE_MSB:0] fall_sel,
	input wire [`ELC_LINE_MSB:0] soft_fire,
	input wire [`ELC_LINE_MSB:0] irq_en,
	input wire [`ELC_LINE_MSB:0] event_en,
	output wire [`ELC_LINE_MSB:0] pend_set,
	output wire [`ELC_LINE_MSB:0] event_fire
);

	genvar i;
	generate
		for (i = 0; i < `ELC_LINES; i = i + 1) begin : g_line
			wire hit;
			// Both selects set give detection in either direction.
			assign hit = (rise[i] & rise_sel[i]) // RL2 RL13
				| (fall[i] & fall_sel[i]) // RL3 RL13
				| soft_fire[i]; // RL4
			assign pend_set[i] = hit & irq_en[i]; // RL12 RL14
			assign event_fire[i] = hit & event_en[i]; // RL1 RL12
		end
	endgenerate

endmodule
`default_nettype wire

// [rtl/elc_top.v]
// Edge line controller: registers, pending flags, interrupt and event outputs.
//
// Contract
// (RL1) Event enable bit gates each line's events.
// (RL2) Rising edge counts only when selected.
// (RL3) Falling edge counts only when selected.
// (RL4) Writing soft trigger one fires the line.
// (RL5) Writing zero withdraws soft request; readable.
// (RL6) Pending bit shows line has been triggered.
// (RL7) Pending cleared by writing one only.
// (RL8) Software keeps bits 31 to 19 zero.
// (RL9) Software uses whole word accesses only.
// (RL10) Control registers reset to zero.
// (RL11) Pending register has no defined reset content.
// (RL12) Interrupt trigger sets pending; event does not.
// (RL13) Both selects detect both edge directions.
// (RL14) Interrupt enable at 0x00 gates interrupts.
// (RL15) Lines 0-15 pins, 16-18 internal sources.
// (RL16) Lines synchronised, edges compare two samples.
`timescale 1ns/10ps
`default_nettype none
`include "elc_map.vh"

module elc_top (
	input wire clock,
	input wire rst,
	input wire [15:0] pin_line,
	input wire low_volt_line,
	input wire rtc_alarm_line,
	input wire usb_wake_line,
	input wire [`ELC_ADDR_W-1:0] addr,
	input wire [`ELC_DATA_W-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [`ELC_DATA_W-1:0] rdata,
	output reg [`ELC_LINE_MSB:0] irq_req,
	output reg [`ELC_LINE_MSB:0] event_pulse,
	output reg any_irq,
	output reg wake_event
);

	localparam SEL_IRQ_EN = 7'h01;
	localparam SEL_EVENT_EN = 7'h02;
	localparam SEL_RISE = 7'h04;
	localparam SEL_FALL = 7'h08;
	localparam SEL_SOFT = 7'h10;
	localparam SEL_PEND = 7'h20;
	localparam SEL_LEVEL = 7'h40;
	localparam SEL_NONE = 7'h00;

	// One-hot register select shared by the write and read paths.
	function [6:0] reg_select;
		input [`ELC_ADDR_W-1:0] a;
		begin
			case (a)
				`ELC_OFF_IRQ_EN: reg_select = SEL_IRQ_EN;
				`ELC_OFF_EVENT_EN: reg_select = SEL_EVENT_EN;
				`ELC_OFF_RISE_SEL: reg_select = SEL_RISE;
				`ELC_OFF_FALL_SEL: reg_select = SEL_FALL;
				`ELC_OFF_SOFT_TRIG: reg_select = SEL_SOFT;
				`ELC_OFF_PENDING: reg_select = SEL_PEND;
				`ELC_OFF_LINE_LEVEL: reg_select = SEL_LEVEL;
				default: reg_select = SEL_NONE;
			endcase
		end
	endfunction

	reg [`ELC_LINE_MSB:0] irq_en;
	reg [`ELC_LINE_MSB:0] event_en;
	reg [`ELC_LINE_MSB:0] rise_sel;
	reg [`ELC_LINE_MSB:0] fall_sel;
	reg [`ELC_LINE_MSB:0] soft_trig;
	reg [`ELC_LINE_MSB:0] pending;

	wire [`ELC_LINE_MSB:0] line_in;
	wire [`ELC_LINE_MSB:0] line_level;
	wire [`ELC_LINE_MSB:0] line_rise;
	wire [`ELC_LINE_MSB:0] line_fall;
	wire [`ELC_LINE_MSB:0] pend_set;
	wire [`ELC_LINE_MSB:0] event_fire;
	wire [`ELC_LINE_MSB:0] wr_bits;
	wire [6:0] wr_sel;
	wire [6:0] rd_sel;
	reg [`ELC_LINE_MSB:0] soft_fire;
	reg [`ELC_LINE_MSB:0] pend_clear;
	reg [`ELC_LINE_MSB:0] next_pending;
	reg [`ELC_LINE_MSB:0] next_irq_req;
	reg [`ELC_LINE_MSB:0] read_bits;

	// Internal sources occupy the top three lines.
	assign line_in = {usb_wake_line, rtc_alarm_line, low_volt_line,
		pin_line}; // RL15

	// Only the line bits are stored; upper write bits are dropped.
	assign wr_bits = wdata[`ELC_LINE_MSB:0]; // RL8
	assign wr_sel = wr ? reg_select(addr) : SEL_NONE;
	assign rd_sel = rd ? reg_select(addr) : SEL_NONE;

	elc_line_sync u_sync (
		.clock(clock),
		.rst(rst),
		.line_in(line_in),
		.level(line_level),
		.rise(line_rise),
		.fall(line_fall)
	);

	elc_trig u_trig (
		.rise(line_rise),
		.fall(line_fall),
		.rise_sel(rise_sel),
		.fall_sel(fall_sel),
		.soft_fire(soft_fire),
		.irq_en(irq_en),
		.event_en(event_en),
		.pend_set(pend_set),
		.event_fire(event_fire)
	);

	// A soft trigger fires once, when a written one meets a cleared bit.
	always @* begin
		soft_fire = {`ELC_LINES{1'b0}};
		if (wr_sel == SEL_SOFT) begin
			soft_fire = wr_bits & ~soft_trig; // RL4
		end
	end

	always @* begin
		pend_clear = {`ELC_LINES{1'b0}};
		if (wr_sel == SEL_PEND) begin
			pend_clear = wr_bits; // RL7
		end
		// A new trigger in the clearing cycle is kept.
		next_pending = (pending & ~pend_clear) | pend_set; // RL6 RL7 RL12
		next_irq_req = next_pending & irq_en; // RL14
	end

	always @(posedge clock) begin
		if (rst) begin
			irq_en <= `ELC_RESET_VAL; // RL10
			event_en <= `ELC_RESET_VAL; // RL10
			rise_sel <= `ELC_RESET_VAL; // RL10
			fall_sel <= `ELC_RESET_VAL; // RL10
			soft_trig <= `ELC_RESET_VAL; // RL10
		end else begin
			if (wr_sel == SEL_IRQ_EN) begin
				irq_en <= wr_bits; // RL14
			end
			if (wr_sel == SEL_EVENT_EN) begin
				event_en <= wr_bits; // RL1
			end
			if (wr_sel == SEL_RISE) begin
				rise_sel <= wr_bits; // RL2
			end
			if (wr_sel == SEL_FALL) begin
				fall_sel <= wr_bits; // RL3
			end
			if (wr_sel == SEL_SOFT) begin
				soft_trig <= wr_bits; // RL5
			end
		end
	end

	// Pending content after reset is not promised to software; it is
	// cleared here so that simulation starts from a known state.
	always @(posedge clock) begin
		if (rst) begin
			pending <= `ELC_PEND_RESET; // RL11
		end else begin
			pending <= next_pending; // RL6
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			irq_req <= {`ELC_LINES{1'b0}};
			any_irq <= 1'b0;
			event_pulse <= {`ELC_LINES{1'b0}};
			wake_event <= 1'b0;
		end else begin
			irq_req <= next_irq_req; // RL14
			any_irq <= |next_irq_req;
			event_pulse <= event_fire; // RL1
			wake_event <= |event_fire;
		end
	end

	always @* begin
		case (rd_sel)
			SEL_IRQ_EN: read_bits = irq_en;
			SEL_EVENT_EN: read_bits = event_en;
			SEL_RISE: read_bits = rise_sel;
			SEL_FALL: read_bits = fall_sel;
			SEL_SOFT: read_bits = soft_trig; // RL5
			SEL_PEND: read_bits = pending; // RL6
			SEL_LEVEL: read_bits = line_level;
			default: read_bits = {`ELC_LINES{1'b0}};
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always @(posedge clock) begin
		if (rst) begin
			rdata <= {`ELC_DATA_W{1'b0}};
		end else if (rd) begin
			rdata <= {{`ELC_PAD_W{1'b0}}, read_bits};
		end else begin
			rdata <= {`ELC_DATA_W{1'b0}};
		end
	end

endmodule
`default_nettype wire

// [tb/elc_top_asserts.sv]
// Port checker for the edge line controller.
`timescale 1ns/10ps
`default_nettype none
module elc_top_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] pin_line,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic [18:0] irq_req,
	input wire logic [18:0] event_pulse,
	input wire logic any_irq
);
	logic [18:0] ie, ev, rs, fs, sw;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Shadows of the control registers, following software writes.
	always @(posedge clock) begin
		if (rst) begin
			{ie, ev, rs, fs, sw} <= '0;
		end else if (wr) begin
			case (addr)
			8'h00: ie <= wdata[18:0];
			8'h04: ev <= wdata[18:0];
			8'h08: rs <= wdata[18:0];
			8'h0c: fs <= wdata[18:0];
			8'h10: sw <= wdata[18:0];
			default: ;
			endcase
		end
	end
	// A pulse launched at one edge was enabled by the value before it.
	property p_ev_gate; (event_pulse & ~$past(ev)) == 19'h0; endproperty
	a_ev_gate: assert property (p_ev_gate) else $error("ev gate");
	property p_rise; $rose(pin_line[0]) && rs[0] && ev[0] |-> ##3
		event_pulse[0]; endproperty
	a_rise: assert property (p_rise) else $error("rise");
	property p_fall; $fell(pin_line[0]) && fs[0] && ev[0] |-> ##3
		event_pulse[0]; endproperty
	a_fall: assert property (p_fall) else $error("fall");
	property p_nofall; $fell(pin_line[0]) && !fs[0] |-> ##3
		!event_pulse[0]; endproperty
	a_nofall: assert property (p_nofall) else $error("nofall");
	property p_soft; wr && addr == 8'h10 && wdata[18] && !sw[18] && ev[18]
		|=> event_pulse[18]; endproperty
	a_soft: assert property (p_soft) else $error("soft");
	property p_any; any_irq == |irq_req; endproperty
	a_any: assert property (p_any) else $error("any");
	property p_clr; wr && addr == 8'h14 && &wdata[18:0] |=>
		irq_req == 19'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_ie; (irq_req & ~$past(ie)) == 19'h0; endproperty
	a_ie: assert property (p_ie) else $error("irq gate");
	c_ev: cover property (|event_pulse);
	c_irq: cover property (any_irq);
	c_clr: cover property (wr && addr == 8'h14);
endmodule
bind elc_top elc_top_checker chk (.clock, .rst, .pin_line, .addr, .wdata,
	.wr, .irq_req, .event_pulse, .any_irq);
`default_nettype wire

// [tb/elc_core_model.sv]
// Core-side model that counts wake events.
`timescale 1ns/10ps
`default_nettype none
module elc_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic wake_event,
	output logic [7:0] wake_count
);
	always @(posedge clock) begin
		if (rst) begin
			wake_count <= 8'h00;
		end else if (wake_event) begin
			wake_count <= wake_count + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [tb/elc_top_test.sv]
// Register-level test of the edge line controller.
`timescale 1ns/10ps
`default_nettype none
module elc_top_test;
	logic clock, rst, wr, rd, any_irq, wake_event;
	logic [18:0] lines, irq_req, event_pulse;
	logic [7:0] addr, wake_count, n_ev;
	logic [31:0] wdata, rdata;
	int failures = 0;
	int n_tests = 0;
	elc_top uut (.clock(clock), .rst(rst), .pin_line(lines[15:0]),
		.low_volt_line(lines[16]), .rtc_alarm_line(lines[17]),
		.usb_wake_line(lines[18]), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq_req(irq_req),
		.event_pulse(event_pulse), .any_irq(any_irq),
		.wake_event(wake_event));
	elc_core_model core (.clock(clock), .rst(rst),
		.wake_event(wake_event), .wake_count(wake_count));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// Five edges cover synchroniser, trigger and the core count.
	task automatic set_line(input int i, input logic v);
		@(posedge clock);
		lines[i] <= v;
		repeat (5) @(posedge clock);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clock);
		failures++;
		final_report;
	end
	initial begin
		{rst, wr, rd, lines, addr, wdata, n_ev} = '0;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int a = 0; a < 'h10; a += 4) begin
			rd_chk(a[7:0], 0);
			wr_reg(a[7:0], 32'h5a5a5);
			rd_chk(a[7:0], 32'h5a5a5);
			wr_reg(a[7:0], 0);
		end
		rd_chk(8'h10, 0);
		rd_chk(8'h1c, 0);
		wr_reg(8'h00, 1);
		wr_reg(8'h04, 1);
		wr_reg(8'h08, 1);
		set_line(0, 1);
		n_ev++;
		chk("wake", n_ev, wake_count);
		chk("irq", 1, irq_req);
		chk("any", 1, any_irq);
		rd_chk(8'h14, 1);
		set_line(0, 0);
		chk("wake", n_ev, wake_count);
		wr_reg(8'h14, 0);
		rd_chk(8'h14, 1);
		wr_reg(8'h14, 32'h7ffff);
		rd_chk(8'h14, 0);
		wr_reg(8'h0c, 1);
		set_line(0, 1);
		set_line(0, 0);
		n_ev += 2;
		chk("wake", n_ev, wake_count);
		wr_reg(8'h14, 32'h7ffff);
		wr_reg(8'h00, 0);
		set_line(0, 1);
		n_ev++;
		chk("wake", n_ev, wake_count);
		rd_chk(8'h14, 0);
		wr_reg(8'h04, 0);
		wr_reg(8'h00, 1);
		set_line(0, 0);
		chk("wake", n_ev, wake_count);
		chk("irq", 1, irq_req);
		wr_reg(8'h14, 32'h7ffff);
		wr_reg(8'h00, 32'h40000);
		wr_reg(8'h04, 32'h40000);
		wr_reg(8'h10, 32'h40000);
		repeat (2) @(posedge clock);
		n_ev++;
		chk("wake", n_ev, wake_count);
		chk("irq", 32'h40000, irq_req);
		rd_chk(8'h10, 32'h40000);
		wr_reg(8'h10, 0);
		rd_chk(8'h10, 0);
		rd_chk(8'h14, 32'h40000);
		wr_reg(8'h14, 32'h7ffff);
		wr_reg(8'h04, 0);
		wr_reg(8'h00, 32'h7ffff);
		wr_reg(8'h08, 32'h7ffff);
		wr_reg(8'h0c, 0);
		for (int i = 0; i < 19; i++) begin
			set_line(i, 1);
			rd_chk(8'h14, 1 << i);
			wr_reg(8'h14, 32'h7ffff);
		end
		rd_chk(8'h18, 32'h7ffff);
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int a = 0; a <= 'h10; a += 4) begin
			rd_chk(a[7:0], 0);
		end
		chk("wake", 0, wake_count);
		chk("irq", 0, irq_req);
		chk("any", 0, any_irq);
		final_report;
	end
endmodule
`default_nettype wire
